// >>> hw/reset_sync_and_strap_control.sv
// Function
// - full reset whenever reset input low for two or more consecutive clock samples
// - reset input synchronised before internal use
// - abort bus: drive inactive, then float
// - strap pins become pulled-up inputs in reset
// - low top address strap requests emulation
module reset_sync_and_strap_control (
  // clock and external reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ext_reset_in_n,
  // core side bus controls and address in run mode
  input rst_pkg::bus_ctrl_t core_ctrl,
  input wire logic core_top_addr,
  input wire logic [rst_pkg::UPPER_ADDR_W-1:0] core_upper_addr,
  // pin level of the top address / emulation strap
  input wire logic top_address_emul_strap_in,
  // bus control pins
  output rst_pkg::bus_ctrl_t ctrl_out,
  output logic ctrl_oe,
  // strap pins: output, enable, weak pull-up
  output logic top_address_emul_strap_out,
  output logic top_address_emul_strap_oe,
  output logic [rst_pkg::UPPER_ADDR_W-1:0] upper_address_bits_out,
  output logic upper_address_bits_oe,
  output logic lock_oe,
  output logic strap_pullup_en,
  // internal reset and mode
  output logic core_reset_q,
  output logic onchip_emulation_mode
);
  logic rin_level;
  logic strap_s1_q, strap_s2_q, strap_s3_q;
  logic strap_level_q, strap_level_d;
  rst_pkg::seq_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic core_reset_d;
  logic emul_q, emul_d;
  rst_pkg::bus_ctrl_t ctrl_d;
  logic ctrl_oe_d, drive_d, pull_d;
  logic top_d;
  logic [rst_pkg::UPPER_ADDR_W-1:0] upper_d;

  reset_in_sync u_rin (
    .core_clk(core_clk),
    .pin_in(ext_reset_in_n),
    .level_q(rin_level)
  );

  always_comb begin
    strap_level_d = strap_level_q;
    if (strap_s2_q == strap_s3_q) begin
      strap_level_d = strap_s3_q;
    end
  end

  always_ff @(posedge core_clk) begin
    strap_s1_q <= top_address_emul_strap_in;
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
    strap_level_q <= strap_level_d;
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    core_reset_d = ~rin_level;
    emul_d = emul_q;
    unique case (state_q)
      rst_pkg::ST_RUN: begin
        if (!rin_level) begin
          state_d = rst_pkg::ST_QUIESCE;
          cnt_d = '0;
        end
      end
      rst_pkg::ST_QUIESCE: begin
        if (cnt_q == rst_pkg::QUIESCE_W'(rst_pkg::QUIESCE_CYCLES - 1)) begin
          state_d = rst_pkg::ST_FLOAT;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      rst_pkg::ST_FLOAT: begin
        if (rin_level) begin
          state_d = rst_pkg::ST_RUN;
          emul_d = ~strap_level_q;
        end
      end
      default: state_d = rst_pkg::ST_QUIESCE;
    endcase
  end

  always_comb begin
    ctrl_d = core_ctrl;
    ctrl_oe_d = 1'h1;
    drive_d = 1'h1;
    pull_d = 1'h0;
    top_d = core_top_addr;
    upper_d = core_upper_addr;
    // emulation mode floats the outputs
    if (emul_d) begin
      ctrl_oe_d = 1'h0;
      drive_d = 1'h0;
    end
    if (state_d != rst_pkg::ST_RUN) begin
      ctrl_d = rst_pkg::CTRL_IDLE;
      ctrl_oe_d = (state_d == rst_pkg::ST_QUIESCE);
      drive_d = 1'h0;
      pull_d = rst_pkg::PULL_LEVEL;
      top_d = rst_pkg::PULL_LEVEL;
      upper_d = {rst_pkg::UPPER_ADDR_W{rst_pkg::PULL_LEVEL}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= rst_pkg::ST_QUIESCE;
      cnt_q <= '0;
      core_reset_q <= 1'h1;
      emul_q <= 1'h0;
      ctrl_out <= rst_pkg::CTRL_IDLE;
      ctrl_oe <= 1'h1;
      top_address_emul_strap_out <= 1'h1;
      top_address_emul_strap_oe <= 1'h0;
      upper_address_bits_out <= '1;
      upper_address_bits_oe <= 1'h0;
      lock_oe <= 1'h0;
      strap_pullup_en <= 1'h1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      core_reset_q <= core_reset_d;
      emul_q <= emul_d;
      ctrl_out <= ctrl_d;
      ctrl_oe <= ctrl_oe_d;
      top_address_emul_strap_out <= top_d;
      top_address_emul_strap_oe <= drive_d;
      upper_address_bits_out <= upper_d;
      upper_address_bits_oe <= drive_d;
      lock_oe <= drive_d;
      strap_pullup_en <= pull_d;
    end
  end

  assign onchip_emulation_mode = emul_q;
endmodule

// >>> hw/rst_pkg.sv
package rst_pkg;
  // synchroniser depth: three stages, change counted when stages two and three agree
  localparam int SYNC_STAGES = 3;
  // cycles the control lines are driven inactive before they float
  localparam int QUIESCE_CYCLES = 1;
  localparam logic [1:0] QUIESCE_W = 2'h2;
  // inactive (deasserted) levels of the bus control outputs
  localparam logic CTRL_RD_N_IDLE = 1'h1;
  localparam logic CTRL_WR_N_IDLE = 1'h1;
  localparam logic CTRL_ALE_IDLE = 1'h0;
  localparam logic CTRL_DEN_N_IDLE = 1'h1;
  localparam logic CTRL_LOCK_N_IDLE = 1'h1;
  // pull-up weak level for the strap pins
  localparam logic PULL_LEVEL = 1'h1;
  localparam int UPPER_ADDR_W = 3;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_QUIESCE,
    ST_FLOAT
  } seq_state_t;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic ale;
    logic den_n;
    logic lock_n;
  } bus_ctrl_t;

  localparam bus_ctrl_t CTRL_IDLE = '{
    rd_n: CTRL_RD_N_IDLE,
    wr_n: CTRL_WR_N_IDLE,
    ale: CTRL_ALE_IDLE,
    den_n: CTRL_DEN_N_IDLE,
    lock_n: CTRL_LOCK_N_IDLE
  };
endpackage

// >>> hw/reset_in_sync.sv
module reset_in_sync (
  // clock only, no reset
  input wire logic core_clk,
  // asynchronous pin
  input wire logic pin_in,
  // filtered level
  output logic level_q
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic level_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin_in};
    level_d = level_q;
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
    end
  end

  // no reset here: this is the reset path itself, it comes up low through the pin
  always_ff @(posedge core_clk) begin
    sync_q <= sync_d;
    level_q <= level_d;
  end
endmodule

// >>> tb/rst_chk.sv
module rst_chk (
  input wire logic core_clk, resetn, ext_reset_in_n, top_address_emul_strap_in,
  input rst_pkg::bus_ctrl_t ctrl_out,
  input wire logic ctrl_oe, top_address_emul_strap_oe, upper_address_bits_oe, lock_oe,
  input wire logic strap_pullup_en, core_reset_q, onchip_emulation_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence quiesce; ctrl_oe ##1 !ctrl_oe; endsequence
  a_rst_entry: assert property (!ext_reset_in_n [*6] |-> core_reset_q)
    else $error("reset not entered");
  a_sync_lag: assert property ($fell(ext_reset_in_n) && !core_reset_q |=> !core_reset_q [*2])
    else $error("reset taken too early");
  a_ctrl_idle: assert property (core_reset_q |-> ctrl_out == rst_pkg::CTRL_IDLE)
    else $error("controls not idle");
  a_drive_float: assert property ($rose(core_reset_q) |-> quiesce)
    else $error("no drive then float");
  a_strap_pull: assert property (core_reset_q |-> strap_pullup_en && !lock_oe
    && !upper_address_bits_oe && !top_address_emul_strap_oe)
    else $error("strap pins not pulled inputs");
  a_mode_latch: assert property ($fell(core_reset_q) |-> onchip_emulation_mode == !$past(top_address_emul_strap_in))
    else $error("mode not latched");
  a_mode_hold: assert property (!core_reset_q && !$past(core_reset_q) |-> $stable(onchip_emulation_mode))
    else $error("mode changed");
  a_emul_float: assert property (!core_reset_q && onchip_emulation_mode |-> !ctrl_oe)
    else $error("bus driven in emulation");
endmodule

bind reset_sync_and_strap_control rst_chk rst_chk_i (.*);

// >>> tb/board_rst.sv
module board_rst (
  input wire logic rst_req, emul_req, strap_out, strap_oe, pullup_en,
  output logic ext_reset_in_n, strap_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // held low from power-on until released
  assign ext_reset_in_n = !rst_req;
  // only the strap is pulled low, in reset
  assign strap_pin = strap_oe ? strap_out : !(emul_req && pullup_en);
endmodule

// >>> tb/reset_sync_and_strap_control_tb.sv
module reset_sync_and_strap_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 0, resetn = 0, rq = 1, er = 0, ext_n, s_in, c_oe, t_oe, u_oe, l_oe, pu, crq, mode, t_out;
  logic [2:0] ua = 3'h5, u_out;
  rst_pkg::bus_ctrl_t cc = 5'h0a, c_out;
  int n_mismatch = 0, checked = 0;
  initial forever #12.5 core_clk = ~core_clk;
  reset_sync_and_strap_control reset_sync_and_strap_control_i (.core_clk, .resetn, .ext_reset_in_n(ext_n),
    .core_ctrl(cc), .core_top_addr(1'b1), .core_upper_addr(ua), .top_address_emul_strap_in(s_in),
    .ctrl_out(c_out), .ctrl_oe(c_oe), .top_address_emul_strap_out(t_out), .top_address_emul_strap_oe(t_oe),
    .upper_address_bits_out(u_out), .upper_address_bits_oe(u_oe), .lock_oe(l_oe), .strap_pullup_en(pu),
    .core_reset_q(crq), .onchip_emulation_mode(mode));
  board_rst board_rst_i (.rst_req(rq), .emul_req(er), .strap_out(t_out), .strap_oe(t_oe),
    .pullup_en(pu), .ext_reset_in_n(ext_n), .strap_pin(s_in));
  task summarize;
    $display("mismatches=%0d checked=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(logic [7:0] g, logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wt(logic v);
    for (int i = 0; i < 20 && crq !== v; i++) @(negedge core_clk);
    if (crq !== v) begin
      n_mismatch++;
      summarize;
    end
  endtask
  task t_exit(logic e);
    er = e;
    repeat (6) @(negedge core_clk);
    rq = 0;
    wt(0);
    chk(mode, e);
    repeat (8) @(negedge core_clk);
    chk(mode, e);
    chk({c_oe, pu, u_oe, u_out}, e ? {3'h0, ua} : {3'h5, ua});
    chk({l_oe, t_oe, t_out}, e ? 8'h01 : 8'h07);
    if (!e) chk(c_out, cc);
  endtask
  task t_entry;
    rq = 1;
    wt(1);
    chk(c_out, rst_pkg::CTRL_IDLE);
    chk({c_oe, l_oe, u_oe, t_oe, pu}, 8'h11);
    @(negedge core_clk);
    chk(c_oe, 0);
  endtask
  task t_glitch;
    rq = 1;
    @(negedge core_clk);
    rq = 0;
    repeat (8) @(negedge core_clk);
    chk(crq, 0);
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    resetn = 1;
    t_exit(0);
    t_glitch;
    t_entry;
    t_exit(1);
    t_entry;
    t_exit(0);
    summarize;
  end
endmodule
